// *** hw/csup_top.sv ***
`timescale 1ns/1ps
module csup_top
  import csup_pkg::*;
#(
  parameter int NUM_PINS = 8
)
(
  input  wire logic                          CORE_CLK,
  input  wire logic                          RSTN,
  input  wire logic                          MEAS_VALID,
  input  wire logic [15:0]                   PACK_VOLTAGE,
  input  wire logic signed [15:0]            PACK_CURRENT,
  input  wire logic [15:0]                   TEMPERATURE,
  input  wire logic [7:0]                    CHARGE_RATE,
  input  wire logic [7:0]                    CHARGE_LEVEL,
  input  wire logic                          TRIGGER_IN,
  input  wire logic [csup_pkg::ADDR_W-1:0]   ADDR,
  input  wire logic [csup_pkg::DATA_W-1:0]   WR_DATA,
  input  wire logic                          WR_STB,
  input  wire logic                          RD_STB,
  output logic [csup_pkg::DATA_W-1:0]        RD_DATA,
  output logic                               FULLY_CHARGED,
  output logic                               OVER_TEMP_ALARM,
  output logic                               STOP_CHARGE_ALARM,
  output logic                               CHARGE_EN,
  output logic                               DISCHARGE_EN,
  output logic [NUM_PINS-1:0]                PIN_OUT
);
  import csup_pkg::*;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);

  logic [15:0]      par_q [0:NUM_PARAMS-1];
  logic [15:0]      cfg_q [0:NUM_PINS-1];
  logic [15:0]      rd_data_q;
  logic [15:0]      rd_mux;
  logic [15:0]      status_w;
  logic             is_par;
  logic             is_cfg;
  logic             is_stat;
  logic             trig_s1_q;
  logic             trig_s2_q;
  csup_phase_t      phase_q;
  csup_phase_t      phase_d;
  logic             charging_now;
  logic             discharging_now;
  logic             charge_start;
  logic [15:0]      hold_cnt_q;
  logic             holdoff_done;
  logic [15:0]      smp_cnt_q;
  logic             sample_pt;
  logic             have_prev_q;
  logic [15:0]      prev_v_q;
  logic signed [15:0] prev_i_q;
  logic [16:0]      v_drop;
  logic signed [16:0] i_diff;
  logic [16:0]      i_dev;
  logic             drop_hit;
  logic             i_stable;
  logic             drop_rate_ok;
  logic             drop_eoc;
  logic [ACC_W-1:0] acc_q;
  logic             oc_rate_ok;
  logic             oc_level_ok;
  logic             oc_hit;
  logic             oc_eoc;
  logic             full_q;
  logic             full_d;
  logic             over_temp;
  logic             stop_chg;
  logic             too_cold;
  logic             lock_q;
  logic             lock_d;
  logic             chg_en_q;
  logic             dsg_en_q;
  logic             ot_q;
  logic             stop_q;
  logic [15:0]      chg_mag;
  logic [15:0]      dsg_mag;
  logic [7:0]       safety_cond;
  logic [7:0]       ctrl_cond;
  logic [NUM_PINS-1:0] pin_w;

  // register port decode; unmapped reads answer zero, writes are dropped
  assign is_par  = ADDR < 5'(NUM_PARAMS);
  assign is_cfg  = ADDR[4:3] == PIN_CFG_PAGE;
  assign is_stat = ADDR == STATUS_ADDR;
  assign status_w = {pin_w, phase_q == PH_CHARGE, holdoff_done, lock_q,
                     dsg_en_q, chg_en_q, stop_q, ot_q, full_q};
  assign rd_mux  = is_par  ? par_q[ADDR] :
                   is_cfg  ? cfg_q[ADDR[2:0]] :
                   is_stat ? status_w : 16'h0000;

  // parameter and pin configuration storage
  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      for (int k = 0; k < NUM_PARAMS; k++)
        par_q[k] <= PARAM_RST;
      for (int k = 0; k < NUM_PINS; k++)
        cfg_q[k] <= {OR_MSK_RST, AND_MSK_RST};
    end
    else if (WR_STB && is_par)
      par_q[ADDR] <= WR_DATA;
    else if (WR_STB && is_cfg)
      cfg_q[ADDR[2:0]] <= WR_DATA;
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
      rd_data_q <= 16'h0000;
    else
      rd_data_q <= RD_STB ? rd_mux : 16'h0000;
  end

  // trigger pin is asynchronous; only the second stage is read
  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      trig_s1_q <= 1'b0;
      trig_s2_q <= 1'b0;
    end
    else
    begin
      trig_s1_q <= TRIGGER_IN;
      trig_s2_q <= trig_s1_q;
    end
  end

  // current direction sets the phase; a new charge restarts detection
  assign charging_now    = PACK_CURRENT > 16'sh0000;
  assign discharging_now = PACK_CURRENT < 16'sh0000;
  assign phase_d = charging_now    ? PH_CHARGE :
                   discharging_now ? PH_DISCHARGE : PH_IDLE;
  assign charge_start = MEAS_VALID && charging_now && phase_q != PH_CHARGE;

  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
      phase_q <= PH_IDLE;
    else if (MEAS_VALID)
    begin
      case (phase_d)
        PH_CHARGE:    phase_q <= PH_CHARGE;
        PH_DISCHARGE: phase_q <= PH_DISCHARGE;
        default:      phase_q <= PH_IDLE;
      endcase
    end
  end

  // holdoff counted in measurements from the start of charge
  assign holdoff_done = hold_cnt_q >= par_q[P_HOLDOFF];

  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
      hold_cnt_q <= 16'h0000;
    else if (charge_start)
      hold_cnt_q <= 16'h0001;
    else if (MEAS_VALID && charging_now && !holdoff_done)
      hold_cnt_q <= hold_cnt_q + 16'h0001;
  end

  // counting from one puts sample points exactly interval pulses apart
  assign sample_pt = smp_cnt_q >= {8'h00, par_q[P_SAMPLE_INT][7:0]};

  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      smp_cnt_q   <= 16'h0000;
      have_prev_q <= 1'b0;
      prev_v_q    <= 16'h0000;
      prev_i_q    <= 16'sh0000;
    end
    else if (charge_start)
    begin
      smp_cnt_q   <= 16'h0001;
      have_prev_q <= 1'b1;
      prev_v_q    <= PACK_VOLTAGE;
      prev_i_q    <= PACK_CURRENT;
    end
    else if (MEAS_VALID && charging_now && sample_pt)
    begin
      smp_cnt_q   <= 16'h0001;
      prev_v_q    <= PACK_VOLTAGE;
      prev_i_q    <= PACK_CURRENT;
    end
    else if (MEAS_VALID && charging_now)
      smp_cnt_q   <= smp_cnt_q + 16'h0001;
  end

  // drop on the whole pack voltage; a rise gives no drop
  assign v_drop = {1'b0, prev_v_q} - {1'b0, PACK_VOLTAGE};
  assign drop_hit = PACK_VOLTAGE <= prev_v_q &&
                    v_drop >= {1'b0, par_q[P_DROP_THRESH]};
  assign i_diff = 17'(PACK_CURRENT) - 17'(prev_i_q);
  assign i_dev  = i_diff[16] ? 17'(-i_diff) : i_diff;
  assign i_stable = i_dev <= {1'b0, par_q[P_STABILITY]};
  assign drop_rate_ok = CHARGE_RATE >= par_q[P_DROP_MIN_RATE][7:0];
  assign drop_eoc = MEAS_VALID && charging_now && !charge_start &&
                    have_prev_q && sample_pt && drop_hit && i_stable &&
                    drop_rate_ok && holdoff_done;

  // charge counted in, scaled so the amount register covers long charges
  assign oc_rate_ok  = CHARGE_RATE < par_q[P_OC_MAX_RATE][7:0];
  assign oc_level_ok = CHARGE_LEVEL >= par_q[P_OC_LEVEL_MIN][7:0];
  assign oc_hit = acc_q[ACC_SHIFT +: 16] >= par_q[P_OC_AMOUNT];
  assign oc_eoc = MEAS_VALID && charging_now && !charge_start && oc_hit &&
                  oc_rate_ok && oc_level_ok && holdoff_done;

  // hold once the top bits are all ones; a single step above 256 can still wrap past them below the amount
  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
      acc_q <= '0;
    else if (charge_start)
      acc_q <= ACC_W'(PACK_CURRENT);
    else if (MEAS_VALID && charging_now && !(&acc_q[ACC_W-1:ACC_SHIFT]))
      acc_q <= acc_q + ACC_W'(PACK_CURRENT);
  end

  // full flag sticks until the next charge; the clear beats a detection
  assign full_d = (drop_eoc || oc_eoc) ? 1'b1 :
                  charge_start ? 1'b0 : full_q;

  // temperature limits, all re-evaluated on each measurement
  assign over_temp = TEMPERATURE > par_q[P_HIGH_TEMP_AL];
  assign stop_chg  = over_temp && charging_now;
  assign too_cold  = TEMPERATURE < par_q[P_CHG_LOW_TEMP];
  // lockout set while charging hot, released only well below the limit
  assign lock_d = (charging_now && TEMPERATURE > par_q[P_CHG_HIGH_TEMP]) ?
                  1'b1 :
                  (TEMPERATURE < HYST_RELEASE_TEMP) ? 1'b0 : lock_q;

  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      full_q   <= 1'b0;
      ot_q     <= 1'b0;
      stop_q   <= 1'b0;
      lock_q   <= 1'b0;
      chg_en_q <= 1'b0;
      dsg_en_q <= 1'b0;
    end
    else if (MEAS_VALID)
    begin
      full_q   <= full_d;
      ot_q     <= over_temp;
      stop_q   <= stop_chg;
      lock_q   <= lock_d;
      chg_en_q <= !too_cold && !lock_d;
      dsg_en_q <= !(discharging_now &&
                    TEMPERATURE > par_q[P_DSG_HIGH_TEMP]);
    end
  end

  // condition vectors for the programmable pins; bit 7 is never true
  assign chg_mag = charging_now ? PACK_CURRENT : 16'h0000;
  assign dsg_mag = discharging_now ? 16'(-PACK_CURRENT) : 16'h0000;
  assign safety_cond[SC_DSG_OC]    = dsg_mag > par_q[P_DSG_OC];
  assign safety_cond[SC_CHG_OC]    = chg_mag > par_q[P_CHG_OC];
  assign safety_cond[SC_LOW_TEMP]  = TEMPERATURE < par_q[P_SAFE_LOW_TEMP];
  assign safety_cond[SC_HIGH_TEMP] = TEMPERATURE > par_q[P_SAFE_HIGH_TEMP];
  assign safety_cond[SC_PACK_OV]   = PACK_VOLTAGE > par_q[P_PACK_OV];
  assign safety_cond[7:5]          = 3'h0;
  assign ctrl_cond[CC_LOW_VOLT]  = PACK_VOLTAGE < par_q[P_TRICKLE_VOLT];
  assign ctrl_cond[CC_TRIGGER]   = trig_s2_q;
  assign ctrl_cond[CC_LOW_TEMP]  = TEMPERATURE < par_q[P_TRICKLE_TEMP];
  assign ctrl_cond[CC_HIGH_TEMP] = TEMPERATURE > par_q[P_SAFE_HIGH_TEMP];
  assign ctrl_cond[CC_CEILING]   = CHARGE_LEVEL > par_q[P_LEVEL_CEILING][7:0];
  assign ctrl_cond[CC_FULL]      = full_d;
  assign ctrl_cond[CC_STOP]      = stop_chg;
  assign ctrl_cond[7]            = 1'b0;

  // one evaluator per pin, all refreshed by the same measurement
  for (genvar g = 0; g < NUM_PINS; g++)
  begin : g_pin
    csup_pin_eval u_pin (
      .clk         (CORE_CLK),
      .rst_n       (RSTN),
      .upd         (MEAS_VALID),
      .mode_ctrl   (par_q[P_PIN_MODE][g]),
      .cfg         (cfg_q[g]),
      .safety_cond (safety_cond),
      .ctrl_cond   (ctrl_cond),
      .pin_q       (pin_w[g])
    );
  end

  assign RD_DATA           = rd_data_q;
  assign FULLY_CHARGED     = full_q;
  assign OVER_TEMP_ALARM   = ot_q;
  assign STOP_CHARGE_ALARM = stop_q;
  assign CHARGE_EN         = chg_en_q;
  assign DISCHARGE_EN      = dsg_en_q;
  assign PIN_OUT           = pin_w;

  a_full_has_cause: assert property (
    !full_q ##1 full_q |-> $past(drop_eoc || oc_eoc))
    else $error("full flag set without a detection");

  a_full_after_hold: assert property (
    $rose(full_q) |-> $past(hold_cnt_q >= par_q[P_HOLDOFF]))
    else $error("end of charge inside holdoff");

  a_drop_rate_gate: assert property (
    $rose(full_q) && !$past(oc_eoc) |->
      $past(CHARGE_RATE >= par_q[P_DROP_MIN_RATE][7:0]))
    else $error("drop detection below minimum rate");

  a_oc_gates: assert property (
    $rose(full_q) && !$past(drop_eoc) |->
      $past(CHARGE_LEVEL >= par_q[P_OC_LEVEL_MIN][7:0] &&
            CHARGE_RATE < par_q[P_OC_MAX_RATE][7:0]))
    else $error("overcharge end without level or rate");

  a_over_temp_flag: assert property (
    MEAS_VALID |=>
      OVER_TEMP_ALARM == $past(TEMPERATURE > par_q[P_HIGH_TEMP_AL]))
    else $error("over-temperature flag wrong");

  a_stop_needs_hot: assert property (
    STOP_CHARGE_ALARM |-> OVER_TEMP_ALARM && phase_q == PH_CHARGE)
    else $error("stop-charge flag without hot charge");

  a_cold_no_charge: assert property (
    MEAS_VALID && TEMPERATURE < par_q[P_CHG_LOW_TEMP] |=> !CHARGE_EN)
    else $error("charging enabled while too cold");

  a_lock_hold: assert property (
    lock_q && MEAS_VALID && TEMPERATURE >= HYST_RELEASE_TEMP |=>
      lock_q && !CHARGE_EN)
    else $error("charge lockout released above 50 C");

  a_dsg_hot_off: assert property (
    MEAS_VALID && discharging_now && TEMPERATURE > par_q[P_DSG_HIGH_TEMP]
      |=> !DISCHARGE_EN)
    else $error("discharging left on while hot");

endmodule // csup_top

// *** hw/csup_pkg.sv ***
package csup_pkg;

  // bus geometry
  localparam int DATA_W = 16;
  localparam int ADDR_W = 5;

  // parameter register indices, also their word offsets on the port
  localparam logic [4:0] P_DROP_MIN_RATE  = 5'h00;
  localparam logic [4:0] P_STABILITY      = 5'h01;
  localparam logic [4:0] P_SAMPLE_INT     = 5'h02;
  localparam logic [4:0] P_HOLDOFF        = 5'h03;
  localparam logic [4:0] P_DROP_THRESH    = 5'h04;
  localparam logic [4:0] P_OC_MAX_RATE    = 5'h05;
  localparam logic [4:0] P_OC_LEVEL_MIN   = 5'h06;
  localparam logic [4:0] P_OC_AMOUNT      = 5'h07;
  localparam logic [4:0] P_HIGH_TEMP_AL   = 5'h08;
  localparam logic [4:0] P_CHG_LOW_TEMP   = 5'h09;
  localparam logic [4:0] P_CHG_HIGH_TEMP  = 5'h0A;
  localparam logic [4:0] P_DSG_HIGH_TEMP  = 5'h0B;
  localparam logic [4:0] P_PACK_OV        = 5'h0C;
  localparam logic [4:0] P_SAFE_HIGH_TEMP = 5'h0D;
  localparam logic [4:0] P_SAFE_LOW_TEMP  = 5'h0E;
  localparam logic [4:0] P_CHG_OC         = 5'h0F;
  localparam logic [4:0] P_DSG_OC         = 5'h10;
  localparam logic [4:0] P_LEVEL_CEILING  = 5'h11;
  localparam logic [4:0] P_TRICKLE_TEMP   = 5'h12;
  localparam logic [4:0] P_TRICKLE_VOLT   = 5'h13;
  localparam logic [4:0] P_PIN_MODE       = 5'h14;
  localparam int         NUM_PARAMS       = 21;
  localparam logic [4:0] STATUS_ADDR      = 5'h15;
  localparam logic [1:0] PIN_CFG_PAGE     = 2'h3;   // addr[4:3], 0x18..0x1F

  // reset values
  localparam logic [15:0] PARAM_RST   = 16'h0000;
  localparam logic [7:0]  AND_MSK_RST = 8'hFF;      // no and-conditions
  localparam logic [7:0]  OR_MSK_RST  = 8'h00;      // no or-conditions

  // 50 C in 0.1 K units: the release point of the charge lockout
  localparam logic [15:0] HYST_RELEASE_TEMP = 16'h0CA0;

  // overcharge accumulator: amount register compares against the top bits
  localparam int ACC_W     = 24;
  localparam int ACC_SHIFT = 8;

  // safety condition positions (and bit n, or bit n+8)
  localparam int SC_DSG_OC    = 0;
  localparam int SC_CHG_OC    = 1;
  localparam int SC_LOW_TEMP  = 2;
  localparam int SC_HIGH_TEMP = 3;
  localparam int SC_PACK_OV   = 4;

  // charge control condition positions
  localparam int CC_LOW_VOLT  = 0;
  localparam int CC_TRIGGER   = 1;
  localparam int CC_LOW_TEMP  = 2;
  localparam int CC_HIGH_TEMP = 3;
  localparam int CC_CEILING   = 4;
  localparam int CC_FULL      = 5;
  localparam int CC_STOP      = 6;

  // status word bit positions
  localparam int ST_FULL     = 0;
  localparam int ST_OVERTEMP = 1;
  localparam int ST_STOP     = 2;
  localparam int ST_CHG_EN   = 3;
  localparam int ST_DSG_EN   = 4;
  localparam int ST_LOCKOUT  = 5;
  localparam int ST_HOLDOFF  = 6;
  localparam int ST_CHARGING = 7;
  localparam int ST_PINS     = 8;

  typedef enum logic [1:0] {PH_IDLE, PH_CHARGE, PH_DISCHARGE} csup_phase_t;

endpackage

// *** hw/csup_pin_eval.sv ***
`timescale 1ns/1ps
module csup_pin_eval
  import csup_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        upd,
  input  wire logic        mode_ctrl,
  input  wire logic [15:0] cfg,
  input  wire logic [7:0]  safety_cond,
  input  wire logic [7:0]  ctrl_cond,
  output logic             pin_q
);

  logic [7:0] cond;
  logic [7:0] and_msk;
  logic [7:0] or_msk;
  logic       and_t;
  logic       or_t;

  // low byte and-mask, high byte or-mask; mode picks the condition set
  assign and_msk = cfg[7:0];
  assign or_msk  = cfg[15:8];
  assign cond    = mode_ctrl ? ctrl_cond : safety_cond;
  // an unselected bit counts as true, so 0xFF with bit 7 never true is off
  assign and_t   = &(~and_msk | cond);
  assign or_t    = |(or_msk & cond);

  // pin only moves on a measurement update, not on config writes
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pin_q <= 1'b0;
    else if (upd)
      pin_q <= and_t || or_t;
  end

  a_pin_from_terms: assert property (@(posedge clk)
    disable iff (!rst_n) upd |=> pin_q == $past(and_t || or_t))
    else $error("pin output does not follow and/or terms");

  a_pin_holds_idle: assert property (@(posedge clk)
    disable iff (!rst_n) !upd |=> $stable(pin_q))
    else $error("pin output moved without an update");

endmodule // csup_pin_eval

// *** verif/csup_pack_model.sv ***
`timescale 1ns/1ps
// far side: charge and discharge switches plus the trigger contact
module csup_pack_model
(
  input  wire logic       clk,
  input  wire logic       press,
  input  wire logic       chg_en,
  input  wire logic       dsg_en,
  input  wire logic [7:0] pins,
  output logic            trigger,
  output logic            chg_on,
  output logic            dsg_on
);
  logic trig_q = 1'b0;
  logic chg_q  = 1'b0;
  logic dsg_q  = 1'b0;
  // any active protection pin opens both switches, whatever the enables say
  always @(posedge clk)
  begin
    trig_q <= press;
    chg_q  <= chg_en && (pins == 8'h00);
    dsg_q  <= dsg_en && (pins == 8'h00);
  end
  assign trigger = trig_q;
  assign chg_on  = chg_q;
  assign dsg_on  = dsg_q;
endmodule // csup_pack_model

// *** verif/csup_top_tb.sv ***
`timescale 1ns/1ps
module csup_top_tb;
  import csup_pkg::*;
  logic               CORE_CLK     = 1'b0;
  logic               RSTN         = 1'b0;
  logic               MEAS_VALID   = 1'b0;
  logic [15:0]        PACK_VOLTAGE = 16'h1000;
  logic signed [15:0] PACK_CURRENT = 16'h0000;
  logic [15:0]        TEMPERATURE  = 16'h0B00;
  logic [7:0]         CHARGE_RATE  = 8'h00;
  logic [7:0]         CHARGE_LEVEL = 8'h40;
  logic [4:0]         ADDR         = 5'h00;
  logic [15:0]        WR_DATA      = 16'h0000;
  logic               WR_STB       = 1'b0;
  logic               RD_STB       = 1'b0;
  logic               press        = 1'b0;
  logic               TRIGGER_IN, FULLY_CHARGED, OVER_TEMP_ALARM;
  logic               STOP_CHARGE_ALARM, CHARGE_EN, DISCHARGE_EN;
  logic [15:0]        RD_DATA;
  logic [7:0]         PIN_OUT;
  int                 failures = 0;
  int                 n_tests  = 0;
  // pins 0..3 watch safety conditions, pins 4..7 charge-control ones
  logic [15:0] pc [8] = '{16'h0218, 16'h00FF, 16'h1FFF, 16'h0011,
                          16'h02FF, 16'h10FF, 16'h01FF, 16'h04FF};
  // parameter words in register order; oc level stays above the temperature and drop test levels
  logic [15:0] pv [NUM_PARAMS] = '{16'h0020, 16'h0002, 16'h0002, 16'h0000,
    16'h0005, 16'h0020, 16'h0050, 16'h0002, 16'h0D00, 16'h0A00, 16'h0D50,
    16'h0E00, 16'h2000, 16'h0D00, 16'h0A00, 16'h012C, 16'h012C, 16'h00C0,
    16'h0A80, 16'h0800, 16'h00F0};

  csup_top #(.NUM_PINS(8)) i_csup_top
  (
    .CORE_CLK(CORE_CLK), .RSTN(RSTN), .MEAS_VALID(MEAS_VALID),
    .PACK_VOLTAGE(PACK_VOLTAGE), .PACK_CURRENT(PACK_CURRENT),
    .TEMPERATURE(TEMPERATURE), .CHARGE_RATE(CHARGE_RATE),
    .CHARGE_LEVEL(CHARGE_LEVEL), .TRIGGER_IN(TRIGGER_IN), .ADDR(ADDR),
    .WR_DATA(WR_DATA), .WR_STB(WR_STB), .RD_STB(RD_STB), .RD_DATA(RD_DATA),
    .FULLY_CHARGED(FULLY_CHARGED), .OVER_TEMP_ALARM(OVER_TEMP_ALARM),
    .STOP_CHARGE_ALARM(STOP_CHARGE_ALARM), .CHARGE_EN(CHARGE_EN),
    .DISCHARGE_EN(DISCHARGE_EN), .PIN_OUT(PIN_OUT)
  );
  csup_pack_model i_csup_pack_model
  (
    .clk(CORE_CLK), .press(press), .chg_en(CHARGE_EN), .dsg_en(DISCHARGE_EN),
    .pins(PIN_OUT), .trigger(TRIGGER_IN), .chg_on(), .dsg_on()
  );

  always #4 CORE_CLK = ~CORE_CLK;

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge CORE_CLK);
    {ADDR, WR_DATA, WR_STB} <= {a, d, 1'b1};
    @(posedge CORE_CLK);
    WR_STB <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rdc(input logic [4:0] a, input logic [15:0] e);
    @(posedge CORE_CLK);
    {ADDR, RD_STB} <= {a, 1'b1};
    @(posedge CORE_CLK);
    RD_STB <= 1'b0;
    #1 chk("rd_data", RD_DATA, e);
  endtask

  // one measurement pulse; returns once the flags have updated
  task automatic meas(input logic [15:0] v, i, t, input logic [7:0] r, l);
    @(posedge CORE_CLK);
    {PACK_VOLTAGE, PACK_CURRENT, TEMPERATURE, CHARGE_RATE, CHARGE_LEVEL,
     MEAS_VALID} <= {v, i, t, r, l, 1'b1};
    @(posedge CORE_CLK);
    MEAS_VALID <= 1'b0;
    #1;
  endtask

  task automatic tcase(input logic [15:0] i, t, input logic [4:0] e);
    meas(16'h1000, i, t, 8'h00, 8'h40);
    chk("flags", 16'({FULLY_CHARGED, OVER_TEMP_ALARM, STOP_CHARGE_ALARM,
                      CHARGE_EN, DISCHARGE_EN}), 16'(e));
  endtask

  task automatic t_reset;
    @(posedge CORE_CLK);
    #1 chk("outs", 16'({FULLY_CHARGED, OVER_TEMP_ALARM, STOP_CHARGE_ALARM,
                        CHARGE_EN, DISCHARGE_EN, PIN_OUT}), 16'h0000);
    rdc(P_HOLDOFF, 16'h0000);
    @(posedge CORE_CLK);
    #1 chk("rd_idle", RD_DATA, 16'h0000);
    rdc(5'h1F, 16'h00FF);
    wr(P_SAFE_HIGH_TEMP, 16'hA5C3);
    rdc(P_SAFE_HIGH_TEMP, 16'hA5C3);
    wr(5'h16, 16'h1234);
    rdc(5'h16, 16'h0000);
    $display("test reset done");
  endtask

  // flags are {full, overtemp, stop, chg_en, dsg_en}
  task automatic t_temp;
    tcase(16'h0064, 16'h0D10, 5'b01111);
    tcase(16'hFF9C, 16'h0D10, 5'b01011);
    tcase(16'hFF9C, 16'h0E10, 5'b01010);
    tcase(16'hFF9C, 16'h0D60, 5'b01011);
    tcase(16'h0064, 16'h0D60, 5'b01101);
    tcase(16'h0000, 16'h0CB0, 5'b00001);
    tcase(16'h0000, 16'h0CA0, 5'b00001);
    tcase(16'h0000, 16'h0C9F, 5'b00011);
    tcase(16'h0000, 16'h09FF, 5'b00001);
    tcase(16'h0064, 16'h0D00, 5'b00011);
    $display("test temperature done");
  endtask

  // only every second charging pulse is a sample point (interval 2)
  task automatic t_drop(input logic [7:0] r, input logic [15:0] di, h,
                        input logic e);
    wr(P_HOLDOFF, h);
    meas(16'h1000, 16'h0000, 16'h0B00, r, 8'h40);
    meas(16'h1000, 16'h0064, 16'h0B00, r, 8'h40);
    chk("full_start", 16'(FULLY_CHARGED), 16'h0000);
    meas(16'h0F00, 16'h0064, 16'h0B00, r, 8'h40);
    chk("full_between", 16'(FULLY_CHARGED), 16'h0000);
    meas(16'h0FFC, 16'h0064, 16'h0B00, r, 8'h40);
    chk("full_small", 16'(FULLY_CHARGED), 16'h0000);
    meas(16'h0F00, 16'h0064, 16'h0B00, r, 8'h40);
    meas(16'h0FF7, 16'h0064 + di, 16'h0B00, r, 8'h40);
    chk("full_drop", 16'(FULLY_CHARGED), 16'(e));
    meas(16'h1000, 16'h0000, 16'h0B00, r, 8'h40);
    chk("full_held", 16'(FULLY_CHARGED), 16'(e));
    $display("test drop done");
  endtask

  // 200 per pulse: the sum meets the amount of 2 after the third pulse,
  // and the count is judged against it at the fourth
  task automatic t_oc(input logic [7:0] r, l, input logic e);
    meas(16'h1000, 16'h0000, 16'h0B00, r, l);
    meas(16'h1000, 16'h00C8, 16'h0B00, r, l);
    meas(16'h1000, 16'h00C8, 16'h0B00, r, l);
    meas(16'h1000, 16'h00C8, 16'h0B00, r, l);
    chk("full_short", 16'(FULLY_CHARGED), 16'h0000);
    meas(16'h1000, 16'h00C8, 16'h0B00, r, l);
    chk("full_count", 16'(FULLY_CHARGED), 16'(e));
    $display("test overcharge done");
  endtask

  // trigger needs the model edge plus two sync stages before the pulse
  task automatic pcase(input logic [15:0] v, i, t, input logic [7:0] l,
                       input logic g, input logic [7:0] sc, cc);
    logic [7:0] e;
    logic [7:0] c;
    for (int p = 0; p < 8; p++)
    begin
      c = (p < 4) ? sc : cc;
      e[p] = (&(c | ~pc[p][7:0])) | (|(c & pc[p][15:8]));
    end
    @(posedge CORE_CLK);
    press <= g;
    repeat (3) @(posedge CORE_CLK);
    meas(v, i, t, 8'h00, l);
    chk("pin_out", 16'(PIN_OUT), 16'(e));
  endtask

  task automatic t_pins;
    rdc(5'h18, 16'h0218);
    pcase(16'h1000, 16'h0000, 16'h0B00, 8'h40, 1'b0, 8'h00, 8'h00);
    pcase(16'h2100, 16'h0000, 16'h0B00, 8'h40, 1'b0, 8'h10, 8'h00);
    pcase(16'h1000, 16'h0000, 16'h0D10, 8'h40, 1'b0, 8'h08, 8'h08);
    pcase(16'h1000, 16'h0000, 16'h0900, 8'h40, 1'b0, 8'h04, 8'h04);
    pcase(16'h1000, 16'h0190, 16'h0B00, 8'h40, 1'b0, 8'h02, 8'h00);
    pcase(16'h1000, 16'hFE70, 16'h0B00, 8'h40, 1'b0, 8'h01, 8'h00);
    pcase(16'h2100, 16'h0000, 16'h0D10, 8'h40, 1'b0, 8'h18, 8'h08);
    pcase(16'h2100, 16'hFE70, 16'h0B00, 8'h40, 1'b0, 8'h11, 8'h00);
    pcase(16'h1000, 16'h0000, 16'h0B00, 8'hC1, 1'b0, 8'h00, 8'h10);
    pcase(16'h0700, 16'h0000, 16'h0B00, 8'h40, 1'b0, 8'h00, 8'h01);
    pcase(16'h1000, 16'h0000, 16'h0B00, 8'h40, 1'b1, 8'h00, 8'h02);
    // pin 7 moved to the stop-charge condition, hot while charging
    pc[7] = 16'h40FF;
    wr(5'h1F, pc[7]);
    pcase(16'h1000, 16'h0064, 16'h0D10, 8'h40, 1'b0, 8'h08, 8'h48);
    // status: pins 2 and 7, charging, holdoff done, both enables, stop, hot
    rdc(STATUS_ADDR, 16'h84DE);
    $display("test pins done");
  endtask

  initial
  begin
    repeat (2) @(posedge CORE_CLK);
    RSTN <= 1'b1;
    t_reset;
    for (int a = 0; a < NUM_PARAMS; a++)
      wr(5'(a), pv[a]);
    for (int p = 0; p < 8; p++)
      wr(5'h18 + 5'(p), pc[p]);
    t_temp;
    t_drop(8'h40, 16'h0000, 16'h000A, 1'b0);
    t_drop(8'h20, 16'h0002, 16'h0000, 1'b1);
    t_drop(8'h1F, 16'h0000, 16'h0000, 1'b0);
    t_drop(8'h40, 16'h0003, 16'h0000, 1'b0);
    t_oc(8'h1F, 8'h50, 1'b1);
    t_oc(8'h20, 8'h50, 1'b0);
    t_oc(8'h1F, 8'h4F, 1'b0);
    t_pins;
    end_sim;
  end

  // hang guard, far beyond the few hundred cycles the run needs
  initial
  begin
    repeat (20000) @(posedge CORE_CLK);
    failures++;
    $display("unexpected run_length: expected end seen hang");
    end_sim;
  end
endmodule // csup_top_tb
